// >>> rtl/mac_timestamp_rx_register_bank.v
// timestamp timer, pin capture, receive read port and receive statistics registers
// What this block does
// - eight-bit quantization correction for timer periods
// - start-time write arms timer output toggling
// - stop control halts toggling, restores default level
// - capture pin latches 64-bit timestamp, two words
// - same capture latches free-running counter snapshot
// - eleven-bit head frame length, header included
// - data read returns and pops four bytes
// - first byte sits in top eight bits
// - after frame end, data waits for length read
// - read port works only in generic protocol
// - back-to-back reads outrun the byte feed and pop partial words
// - count every received frame, good or bad
// - separate broadcast and multicast frame counts
// - unicast frame count, reset to zero
// - fcs error frame count, reset to zero
// - timer steps sixteen nanoseconds at 120 MHz
// - stop is write-only bit three, self-clearing
`timescale 1ns/1ps
`default_nettype none
`include "mac_ts_rx_defines.vh"

module mac_timestamp_rx_register_bank (
   input  wire        clk_sys,
   input  wire        srst,
   // register access from the spi front end
   input  wire [7:0]  regAddr,
   input  wire        regWrite,
   input  wire [31:0] regWrData,
   input  wire        regRead,
   output reg  [31:0] regRdData,
   output reg         regRdValid,
   // protocol selection and timer settings held elsewhere
   input  wire        genericSpiMode,
   input  wire        timerDefaultLevel,
   input  wire [31:0] timerHighPeriod,
   input  wire [31:0] timerLowPeriod,
   // time base
   input  wire [63:0] timestampNow,
   input  wire [31:0] freeRunNow,
   input  wire        external_capture_pin,
   output reg         periodic_time_output,
   // receive fifo head
   input  wire [10:0] headFrameLength,
   input  wire        rxByteValid,
   input  wire [7:0]  rxByteData,
   output wire        rxByteReady,
   // receive statistics events, one-cycle pulses
   input  wire        rxFrameEvent,
   input  wire        rxBroadcastEvent,
   input  wire        rxMulticastEvent,
   input  wire        rxUnicastEvent,
   input  wire        rxFcsErrorEvent
);

   // armed waits on the start time; run counts ticks into the phase
   localparam [1:0] TIMER_IDLE  = 2'h0;
   localparam [1:0] TIMER_ARMED = 2'h1;
   localparam [1:0] TIMER_RUN   = 2'h2;

   reg  [7:0]  quant_correction_value;
   reg  [31:0] output_start_time;
   reg  [63:0] captured_pin_timestamp;
   reg  [31:0] captured_freerun_value;
   reg         captureSync1;
   reg         captureSync2;
   reg         captureSeen;
   reg  [4:0]  tickSlot;
   reg  [1:0]  timerState;
   reg  [31:0] phaseNs;

   wire        tickEn;
   wire        captureRise;
   wire        writeStart;
   wire        output_stop_control;
   wire        readLength;
   wire        readPort;
   wire        popWord;
   wire [31:0] fifo_read_word;
   wire        frameOpen;
   wire [32:0] nextPhase;
   wire [32:0] phaseLimit;
   wire [31:0] received_frames_total;
   wire [31:0] received_broadcast_total;
   wire [31:0] received_multicast_total;
   wire [31:0] received_unicast_total;
   wire [31:0] received_fcs_error_total;
   reg  [31:0] next_rdData;

   // write decode
   // writes to read-only and unmapped offsets fall through untouched
   assign writeStart          = regWrite && (regAddr == `ADDR_START_TIME);
   // stop bit is never stored, so it reads back as zero
   assign output_stop_control = regWrite && (regAddr == `ADDR_TIMER_CFG)
                                && regWrData[`STOP_BIT_POS];

   always @(posedge clk_sys) begin
      if (srst) begin
         quant_correction_value <= `ZERO_QUANT;
         output_start_time      <= `ZERO_WORD;
      end else if (regWrite) begin
         if (regAddr == `ADDR_QUANT_CORR) begin
            quant_correction_value <= regWrData[`QUANT_CORR_WIDTH-1:0];
         end else if (regAddr == `ADDR_START_TIME) begin
            output_start_time <= regWrData;
         end
      end
   end

   // timer tick: 24 slots of every 25 system cycles, 120 MHz against 125 MHz
   always @(posedge clk_sys) begin
      if (srst) begin
         tickSlot <= 5'h00;
      end else if (tickSlot == `TICK_SLOT_LAST) begin
         tickSlot <= 5'h00;
      end else begin
         tickSlot <= tickSlot + 5'h01;
      end
   end
   assign tickEn = (tickSlot != `TICK_SLOT_LAST);

   // correction stretches each phase; host keeps it 0 to 15
   // the high period applies while the output is high, the low one otherwise
   assign nextPhase  = {1'b0, phaseNs} + `NS_PER_TICK;
   assign phaseLimit = {1'b0, (periodic_time_output ? timerHighPeriod : timerLowPeriod)}
                       + {25'h000_0000, quant_correction_value};

   always @(posedge clk_sys) begin
      if (srst) begin
         timerState           <= TIMER_IDLE;
         phaseNs              <= `ZERO_WORD;
         periodic_time_output <= 1'b0;
      end else if (writeStart) begin
         // a fresh start always rearms, even while running
         timerState           <= TIMER_ARMED;
         phaseNs              <= `ZERO_WORD;
         periodic_time_output <= timerDefaultLevel;
      end else if (output_stop_control) begin
         timerState           <= TIMER_IDLE;
         phaseNs              <= `ZERO_WORD;
         periodic_time_output <= timerDefaultLevel;
      end else begin
         case (timerState)
            TIMER_IDLE: begin
               periodic_time_output <= timerDefaultLevel;
            end
            TIMER_ARMED: begin
               periodic_time_output <= timerDefaultLevel;
               // plain compare: a start time in the past fires at once
               if (timestampNow[31:0] >= output_start_time) begin
                  timerState           <= TIMER_RUN;
                  periodic_time_output <= ~timerDefaultLevel;
               end
            end
            TIMER_RUN: begin
               if (tickEn) begin
                  if (nextPhase >= phaseLimit) begin
                     phaseNs              <= `ZERO_WORD;
                     periodic_time_output <= ~periodic_time_output;
                  end else begin
                     phaseNs <= nextPhase[31:0];
                  end
               end
            end
            default: begin
               timerState <= TIMER_IDLE;
            end
         endcase
      end
   end

   // capture pin comes from outside, two flops before any use
   always @(posedge clk_sys) begin
      if (srst) begin
         captureSync1 <= 1'b0;
         captureSync2 <= 1'b0;
         captureSeen  <= 1'b0;
      end else begin
         captureSync1 <= external_capture_pin;
         captureSync2 <= captureSync1;
         captureSeen  <= captureSync2;
      end
   end
   // edge flop idles low like the pin, so no false capture after reset
   assign captureRise = captureSync2 && !captureSeen;

   always @(posedge clk_sys) begin
      if (srst) begin
         captured_pin_timestamp <= {`ZERO_WORD, `ZERO_WORD};
         captured_freerun_value <= `ZERO_WORD;
      end else if (captureRise) begin
         captured_pin_timestamp <= timestampNow;
         captured_freerun_value <= freeRunNow;
      end
   end

   // receive read port
   assign readLength = regRead && (regAddr == `ADDR_HEAD_LENGTH);
   assign readPort   = regRead && (regAddr == `ADDR_READ_PORT);
   // a read that outruns the byte feed gets a partial word and still pops
   // framed protocol leaves the fifo untouched
   assign popWord    = readPort && genericSpiMode && frameOpen;

   rx_word_packer u_packer (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .loadFrame  (readLength && genericSpiMode),
      .loadLength (headFrameLength),
      .popWord    (popWord),
      .byteValid  (rxByteValid),
      .byteData   (rxByteData),
      .byteReady  (rxByteReady),
      .packedWord (fifo_read_word),
      .frameOpen  (frameOpen)
   );

   // statistics
   // events are single-cycle pulses, each worth one count
   stat_counter u_cnt_all (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .countEvent (rxFrameEvent),
      .countValue (received_frames_total)
   );

   stat_counter u_cnt_bcast (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .countEvent (rxBroadcastEvent),
      .countValue (received_broadcast_total)
   );

   stat_counter u_cnt_mcast (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .countEvent (rxMulticastEvent),
      .countValue (received_multicast_total)
   );

   stat_counter u_cnt_ucast (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .countEvent (rxUnicastEvent),
      .countValue (received_unicast_total)
   );

   stat_counter u_cnt_fcs (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .countEvent (rxFcsErrorEvent),
      .countValue (received_fcs_error_total)
   );

   // read decode; unmapped and write-only addresses read zero
   always @* begin
      next_rdData = `ZERO_WORD;
      if (regAddr == `ADDR_QUANT_CORR) begin
         next_rdData = {24'h00_0000, quant_correction_value};
      end else if (regAddr == `ADDR_START_TIME) begin
         next_rdData = output_start_time;
      end else if (regAddr == `ADDR_STAMP_LOW) begin
         next_rdData = captured_pin_timestamp[31:0];
      end else if (regAddr == `ADDR_STAMP_HIGH) begin
         next_rdData = captured_pin_timestamp[63:32];
      end else if (regAddr == `ADDR_FREERUN_SNAP) begin
         next_rdData = captured_freerun_value;
      end else if (regAddr == `ADDR_HEAD_LENGTH) begin
         next_rdData = {21'h00_0000, headFrameLength};
      end else if (regAddr == `ADDR_READ_PORT) begin
         if (genericSpiMode && frameOpen) begin
            next_rdData = fifo_read_word;
         end
      end else if (regAddr == `ADDR_RX_ALL_COUNT) begin
         next_rdData = received_frames_total;
      end else if (regAddr == `ADDR_RX_BCAST_COUNT) begin
         next_rdData = received_broadcast_total;
      end else if (regAddr == `ADDR_RX_MCAST_COUNT) begin
         next_rdData = received_multicast_total;
      end else if (regAddr == `ADDR_RX_UCAST_COUNT) begin
         next_rdData = received_unicast_total;
      end else if (regAddr == `ADDR_RX_FCS_COUNT) begin
         next_rdData = received_fcs_error_total;
      end
   end

   // read data holds between reads, so a slow front end may take it late
   always @(posedge clk_sys) begin
      if (srst) begin
         regRdData  <= `ZERO_WORD;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRead;
         if (regRead) begin
            regRdData <= next_rdData;
         end
      end
   end

endmodule // mac_timestamp_rx_register_bank
`default_nettype wire

// >>> rtl/mac_ts_rx_defines.vh
// register offsets, field positions and timing constants of the timestamp and receive bank
`ifndef MAC_TS_RX_DEFINES_VH
`define MAC_TS_RX_DEFINES_VH

`define ADDR_TIMER_CFG          8'h84
`define ADDR_QUANT_CORR         8'h87
`define ADDR_START_TIME         8'h88
`define ADDR_STAMP_LOW          8'h89
`define ADDR_STAMP_HIGH         8'h8a
`define ADDR_FREERUN_SNAP       8'h8b
`define ADDR_HEAD_LENGTH        8'h90
`define ADDR_READ_PORT          8'h91
`define ADDR_RX_ALL_COUNT       8'ha0
`define ADDR_RX_BCAST_COUNT     8'ha1
`define ADDR_RX_MCAST_COUNT     8'ha2
`define ADDR_RX_UCAST_COUNT     8'ha3
`define ADDR_RX_FCS_COUNT       8'ha4

`define STOP_BIT_POS            3
`define QUANT_CORR_WIDTH        8
`define LENGTH_WIDTH            11
`define ZERO_WORD               32'h0000_0000
`define ZERO_QUANT              8'h00
`define ZERO_LENGTH             11'h000
`define COUNT_STEP              32'h0000_0001

// nanosecond step per timer tick, and tick rate against the system clock
`define NS_PER_TICK             33'h0_0000_0010
`define TIMER_CLK_MHZ           120
`define SYS_CLK_MHZ             125
`define TICK_SLOT_LAST          5'h18

`endif

// >>> rtl/rx_word_packer.v
// gathers receive fifo bytes into words, first byte in the top lane, gated per frame
`timescale 1ns/1ps
`default_nettype none
`include "mac_ts_rx_defines.vh"

module rx_word_packer (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        loadFrame,
   input  wire [10:0] loadLength,
   input  wire        popWord,
   input  wire        byteValid,
   input  wire [7:0]  byteData,
   output wire        byteReady,
   output reg  [31:0] packedWord,
   output wire        frameOpen
);

   reg  [10:0] bytesLeft;
   reg  [2:0]  lanesFilled;
   wire        wordFull;
   wire        takeByte;

   assign wordFull  = (lanesFilled == 3'h4);
   assign frameOpen = (bytesLeft != `ZERO_LENGTH) || (lanesFilled != 3'h0);
   assign byteReady = (bytesLeft != `ZERO_LENGTH) && !wordFull && !popWord && !loadFrame;
   assign takeByte  = byteValid && byteReady;

   always @(posedge clk_sys) begin
      if (srst) begin
         bytesLeft   <= `ZERO_LENGTH;
         lanesFilled <= 3'h0;
         packedWord  <= `ZERO_WORD;
      end else if (loadFrame) begin
         bytesLeft   <= loadLength;
         lanesFilled <= 3'h0;
         packedWord  <= `ZERO_WORD;
      end else if (popWord) begin
         lanesFilled <= 3'h0;
         packedWord  <= `ZERO_WORD;
      end else if (takeByte) begin
         bytesLeft   <= bytesLeft - 11'h001;
         lanesFilled <= lanesFilled + 3'h1;
         // earliest byte lands in bits 31:24
         case (lanesFilled)
            3'h0: packedWord[31:24] <= byteData;
            3'h1: packedWord[23:16] <= byteData;
            3'h2: packedWord[15:8]  <= byteData;
            default: packedWord[7:0] <= byteData;
         endcase
      end
   end

endmodule // rx_word_packer
`default_nettype wire

// >>> rtl/stat_counter.v
// 32-bit statistics counter, wraps at all ones, cleared only by reset
`timescale 1ns/1ps
`default_nettype none
`include "mac_ts_rx_defines.vh"

module stat_counter (
   input  wire        clk_sys,
   input  wire        srst,
   input  wire        countEvent,
   output reg  [31:0] countValue
);

   always @(posedge clk_sys) begin
      if (srst) begin
         countValue <= `ZERO_WORD;
      end else if (countEvent) begin
         // natural overflow gives the wrap to zero
         countValue <= countValue + `COUNT_STEP;
      end
   end

endmodule // stat_counter
`default_nettype wire

// >>> tb/mac_timestamp_rx_register_bank_tb.sv
// self-checking bench for the timestamp and receive register bank
`timescale 1ns/1ps
`default_nettype none
`include "mac_ts_rx_defines.vh"
module mac_timestamp_rx_register_bank_tb;
   logic clk_sys = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0, regRdValid;
   logic genericSpiMode = 1'b1, timerDefaultLevel = 1'b1, stall = 1'b0, rxByteReady;
   logic external_capture_pin = 1'b0, periodic_time_output, rxByteValid;
   logic rxFrameEvent = 1'b0, rxBroadcastEvent = 1'b0, rxMulticastEvent = 1'b0;
   logic rxUnicastEvent = 1'b0, rxFcsErrorEvent = 1'b0, prev;
   logic [7:0]  regAddr = 8'h00, rxByteData, frm[16];
   logic [10:0] headFrameLength;
   logic [31:0] regWrData = 32'h0000_0000, regRdData, freeRunNow = 32'h0000_0000;
   logic [31:0] timerHighPeriod = 32'h0000_0040, timerLowPeriod = 32'h0000_0080;
   logic [31:0] expQ[$], cnt[5], fr;
   logic [63:0] timestampNow = 64'h0000_0000_0000_0000, ts;
   logic [7:0]  regs[14] = '{8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h90, 8'h91,
                             8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'h84, 8'h8c};
   logic [4:0]  ev;
   integer      seed = 32'h53bb_660d;
   integer      fail_count = 0;
   integer      compares = 0;
   integer      tog;
   always #4 clk_sys = ~clk_sys;
   mac_timestamp_rx_register_bank mac_timestamp_rx_register_bank_i (
      .clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .regRdValid(regRdValid), .genericSpiMode(genericSpiMode),
      .timerDefaultLevel(timerDefaultLevel), .timerHighPeriod(timerHighPeriod),
      .timerLowPeriod(timerLowPeriod), .timestampNow(timestampNow),
      .freeRunNow(freeRunNow), .external_capture_pin(external_capture_pin),
      .periodic_time_output(periodic_time_output), .headFrameLength(headFrameLength),
      .rxByteValid(rxByteValid), .rxByteData(rxByteData), .rxByteReady(rxByteReady),
      .rxFrameEvent(rxFrameEvent), .rxBroadcastEvent(rxBroadcastEvent),
      .rxMulticastEvent(rxMulticastEvent), .rxUnicastEvent(rxUnicastEvent),
      .rxFcsErrorEvent(rxFcsErrorEvent));
   rx_fifo_model rx_fifo_model_i (
      .clk_sys(clk_sys), .rxByteReady(rxByteReady), .stall(stall),
      .rxByteValid(rxByteValid), .rxByteData(rxByteData),
      .headFrameLength(headFrameLength));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one register cycle; a read files its expected word for the monitor
   task automatic acc(input logic [7:0] a, input logic wr, input logic [31:0] d);
      regAddr = a;
      regWrite = wr;
      regRead = !wr;
      regWrData = d;
      if (!wr) expQ.push_back(d);
      tick(1);
      regWrite = 1'b0;
      regRead = 1'b0;
      // a free edge keeps the next call from raising a strobe in this step
      tick(1);
   endtask
   // read answers are looked at mid-cycle, once settled
   always @(negedge clk_sys) begin
      if (regRdValid === 1'b1) begin
         check("read data", regRdData, expQ.pop_front());
      end
   end
   task automatic frame(input int n);
      logic [31:0] w;
      for (int i = 0; i < n; i++) begin
         frm[i] = 8'($random(seed));
         rx_fifo_model_i.push(frm[i]);
      end
      stall = 1'b1;
      acc(`ADDR_HEAD_LENGTH, 1'b0, 32'(n));
      tick(3);
      stall = 1'b0;
      for (int k = 0; k < n; k += 4) begin
         tick(6);
         w = 32'h0000_0000;
         for (int j = 0; j < 4; j++) begin
            if (k + j < n) w[31 - 8 * j -: 8] = frm[k + j];
         end
         acc(`ADDR_READ_PORT, 1'b0, w);
      end
      tick(6);
      acc(`ADDR_READ_PORT, 1'b0, 32'h0000_0000);
   endtask
   task automatic conclude;
      check("pending reads", expQ.size(), 0);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end
      else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(8 * 5000);
      fail_count = fail_count + 1;
      conclude();
   end
   initial begin
      tick(10);
      srst = 1'b0;
      foreach (regs[i]) acc(regs[i], 1'b0, 32'h0000_0000);
      foreach (regs[i]) if (regs[i] != 8'h88) acc(regs[i], 1'b1, 32'hffff_ffff);
      foreach (regs[i]) acc(regs[i], 1'b0, {24'h00_0000, {8{regs[i] == 8'h87}}});
      cnt = '{default: 32'h0000_0000};
      // wrap at all ones is out of reach without a shorter counter
      for (int c = 0; c < 40; c++) begin
         ev = 5'($random(seed));
         {rxFcsErrorEvent, rxUnicastEvent, rxMulticastEvent, rxBroadcastEvent, rxFrameEvent} = ev;
         for (int e = 0; e < 5; e++) cnt[e] += ev[e];
         tick(1);
      end
      {rxFcsErrorEvent, rxUnicastEvent, rxMulticastEvent, rxBroadcastEvent, rxFrameEvent} = 5'h00;
      tick(2);
      for (int e = 0; e < 5; e++) acc(8'ha0 + 8'(e), 1'b0, cnt[e]);
      ts = {$random(seed), $random(seed)};
      fr = $random(seed);
      timestampNow = ts;
      freeRunNow = fr;
      external_capture_pin = 1'b1;
      tick(6);
      timestampNow = ~ts;
      freeRunNow = ~fr;
      external_capture_pin = 1'b0;
      acc(`ADDR_STAMP_LOW, 1'b0, ts[31:0]);
      acc(`ADDR_STAMP_HIGH, 1'b0, ts[63:32]);
      acc(`ADDR_FREERUN_SNAP, 1'b0, fr);
      frame(7);
      frame(12);
      for (int q = 0; q < 2; q++) begin
         acc(`ADDR_QUANT_CORR, 1'b1, q ? 32'h0000_000f : 32'h0000_0000);
         timestampNow = 64'h0000_0000_0000_0100;
         acc(`ADDR_START_TIME, 1'b1, 32'h0000_0200);
         acc(`ADDR_START_TIME, 1'b0, 32'h0000_0200);
         tick(10);
         check("armed level", periodic_time_output, 1'b1);
         timestampNow[31:0] = 32'h0000_0200;
         tick(10);
         tog = 0;
         repeat (100) begin
            prev = periodic_time_output;
            tick(1);
            tog += (periodic_time_output !== prev);
         end
         // 4+8 ticks per period bare, 5+9 with correction, 96 ticks seen
         check("toggles", tog >= 15 - 3 * q && tog <= 17 - 2 * q, 1'b1);
         acc(`ADDR_TIMER_CFG, 1'b1, 32'h0000_0008);
         tog = 0;
         repeat (20) begin
            tick(1);
            tog += (periodic_time_output !== 1'b1);
         end
         check("stopped level", tog, 0);
      end
      genericSpiMode = 1'b0;
      rx_fifo_model_i.push(8'h5a);
      acc(`ADDR_READ_PORT, 1'b0, 32'h0000_0000);
      tick(6);
      check("fifo kept", rx_fifo_model_i.bytes.size(), 1);
      conclude();
   end
endmodule // mac_timestamp_rx_register_bank_tb
`default_nettype wire

// >>> tb/mac_ts_rx_assertions.sv
// port-level assertions for the timestamp and receive register bank
`timescale 1ns/1ps
`default_nettype none
module mac_ts_rx_assertions (
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrite,
   input wire logic [31:0] regWrData,
   input wire logic        regRead,
   input wire logic [31:0] regRdData,
   input wire logic        regRdValid,
   input wire logic        genericSpiMode,
   input wire logic        timerDefaultLevel,
   input wire logic [10:0] headFrameLength,
   input wire logic        periodic_time_output
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   read_answer_a: assert property (regRead |=> regRdValid)
      else $error("read not answered next cycle");
   stray_answer_a: assert property (!regRead |=> !regRdValid)
      else $error("answer without a read");
   length_field_a: assert property (regRead && regAddr == 8'h90 && genericSpiMode
      |=> regRdData == {21'h00_0000, $past(headFrameLength)})
      else $error("head length read wrong");
   framed_idle_a: assert property (regRead && regAddr == 8'h91 && !genericSpiMode
      |=> regRdData == 32'h0000_0000) else $error("read port active in framed mode");
   stop_readback_a: assert property (regRead && regAddr == 8'h84
      |=> regRdData == 32'h0000_0000) else $error("stop control reads back");
   quant_upper_a: assert property (regRead && regAddr == 8'h87
      |=> regRdData[31:8] == 24'h00_0000) else $error("correction upper bits set");
   stop_level_a: assert property (regWrite && regAddr == 8'h84 && regWrData[3]
      |=> periodic_time_output == $past(timerDefaultLevel)) else $error("stop level wrong");
   start_arm_a: assert property (regWrite && regAddr == 8'h88
      |=> periodic_time_output == $past(timerDefaultLevel)) else $error("arm level wrong");
endmodule // mac_ts_rx_assertions
bind mac_timestamp_rx_register_bank mac_ts_rx_assertions mac_ts_rx_assertions_i (
   .clk_sys, .srst, .regAddr, .regWrite, .regWrData, .regRead, .regRdData, .regRdValid,
   .genericSpiMode, .timerDefaultLevel, .headFrameLength, .periodic_time_output);
`default_nettype wire

// >>> tb/rx_fifo_model.sv
// behavioural receive fifo feeding bytes to the register bank
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_model (
   input  wire logic        clk_sys,
   input  wire logic        rxByteReady,
   input  wire logic        stall,
   output var  logic        rxByteValid,
   output var  logic [7:0]  rxByteData,
   output var  logic [10:0] headFrameLength
);
   logic [7:0] bytes[$];
   logic       take;
   initial begin
      rxByteValid = 1'b0;
      rxByteData = 8'h00;
      headFrameLength = 11'h000;
   end
   // updates after the bench's own drive so pushes land first
   always @(posedge clk_sys) begin
      take = rxByteValid && rxByteReady;
      #2;
      if (take) begin
         void'(bytes.pop_front());
      end
      rxByteValid = (bytes.size() != 0) && !stall;
      // idle data toggles so a stale byte can never look valid
      rxByteData = rxByteValid ? bytes[0] : ~rxByteData;
   end
   task automatic push(input logic [7:0] b);
      bytes.push_back(b);
      headFrameLength = 11'(bytes.size());
   endtask
endmodule // rx_fifo_model
`default_nettype wire
